/* File: rtl/cbec_pkg.sv */
// Purpose: Shared constants and types for the cache and bus error checker.
// Assumes: 32-bit APB register port, one 25 MHz clock.
// Notes: ECC codes are generic SECDED codes built by cbec_secded.
package cbec_pkg;
   // Datapath widths.
   localparam int L2D_W = 64;
   localparam int L2D_CHK_W = 10;
   localparam int L2D_PAR_BIT = 9;
   localparam int L2D_ECC_W = 9;
   localparam int TAG_W = 26;
   localparam int TAG_CHK_W = 7;
   localparam int CMD_W = 12;
   localparam int AD_W = 64;
   localparam int AD_CHK_W = 8;
   localparam int STATE_W = 3;
   localparam int RESP_W = 5;
   localparam int IDX_W = 16;
   localparam int IBUF_N = 4;
   localparam int IBUF_IDX_W = 2;
   localparam int PERF_W = 32;
   // Command bus field positions.
   localparam int CMD_CHK_EN_BIT = 0;
   localparam int CMD_ENTRY_LSB = 1;
   localparam int CMD_QUAL_BIT = 5;
   localparam int CMD_DATA_BIT = 11;
   // Register map, byte addresses.
   localparam int APB_AW = 12;
   localparam logic [APB_AW-1:0] REG_CTRL = 12'h000;
   localparam logic [APB_AW-1:0] REG_FAULT = 12'h004;
   localparam logic [APB_AW-1:0] REG_PERF0 = 12'h008;
   // Control and fault register fields.
   localparam int CTRL_CORR_EN_BIT = 0;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam int FLT_D_BIT = 0;
   localparam int FLT_TA_BIT = 1;
   localparam int FLT_SC_BIT = 2;
   localparam int FLT_SA_BIT = 3;
   localparam int FLT_EE_BIT = 4;
   localparam int FLT_RP_BIT = 5;
   localparam int FLT_FLAGS_W = 6;
   localparam int FLT_IDX_LSB = 16;
   localparam logic [FLT_FLAGS_W-1:0] FLT_FLAGS_RST = 6'h00;
   localparam logic [IDX_W-1:0] FLT_IDX_RST = 16'h0000;
   localparam logic [PERF_W-1:0] PERF_RST = 32'h0000_0000;

   typedef struct packed {
      logic valid_n;
      logic [CMD_W-1:0] cmd;
      logic cmd_par;
      logic [AD_W-1:0] ad;
      logic [AD_CHK_W-1:0] ad_chk;
   } cbec_sysbus_t;

   typedef enum logic [1:0] {
      DS_IDLE = 2'b01,
      DS_REREAD = 2'b10
   } cbec_dstate_t;
endpackage : cbec_pkg

/* File: rtl/cbec_secded.sv */
// Purpose: Generic single-error-correct, double-error-detect generator and checker.
// Assumes: Check bits are R-1 Hamming bits plus one overall parity bit on top.
// Notes: Data bit j sits at the j-th code position that is not a power of two.
module cbec_secded #(
   parameter int K = 64,
   parameter int R = 9
) (
   input wire logic [K-1:0] data,
   input wire logic [R-1:0] chk,
   output logic [R-1:0] gen,
   output logic [K-1:0] fixed,
   output logic ce,
   output logic ue
);
   function automatic int dpos(int j);
      int n;
      int p;
      n = 0;
      for (p = 3; p < 4096; p++) begin
         if ((p & (p - 1)) != 0) begin
            if (n == j) return p;
            n++;
         end
      end
      return 0;
   endfunction : dpos

   logic [R-2:0][K-1:0] contrib;
   logic [R-2:0] ham;
   logic [R-2:0] syn;
   logic overall;

   for (genvar i = 0; i < R - 1; i++) begin : g_row
      for (genvar j = 0; j < K; j++) begin : g_col
         localparam int P = dpos(j);
         assign contrib[i][j] = P[i] ? data[j] : 1'b0;
      end
      assign ham[i] = ^contrib[i];
   end

   assign syn = ham ^ chk[R-2:0];
   assign overall = (^data) ^ (^chk);
   assign gen = {(^data) ^ (^ham), ham};
   // A single error flips overall parity; a double error leaves it even.
   assign ce = overall;
   assign ue = ~overall & (|syn);

   for (genvar j = 0; j < K; j++) begin : g_fix
      localparam int PJ = dpos(j);
      assign fixed[j] = data[j] ^ (overall && (syn == PJ[R-2:0]));
   end
endmodule : cbec_secded

/* File: rtl/cbec_top.sv */
// Purpose: Cache data/tag and system bus error detection, correction and reporting.
// Assumes: All inputs synchronous to clk; APB slave with one wait state.
// Notes: Error pulses and exceptions are registered, one cycle after the cause.
// Functional notes
// - Without correction enable, data reads check even parity on check bit 9.
// - A parity failure re-reads the block through the corrector using bits 8:0.
// - Correctable re-read data is fixed and the correctable pulse fires once.
// - Uncorrectable re-read raises cache exception, data flag and line index.
// - Correctable data array errors bump performance counter 0.
// - Each 26-bit tag carries a 7-bit ECC code.
// - Tag reads are checked, fixed in-line, correctable pulse fires.
// - Uncorrectable tag raises exception, tag flag, index, uncorrectable pulse.
// - Tag writes drive the generated 7-bit code on the tag check bus.
// - As master with valid asserted, drive odd command parity.
// - Agent supplies odd parity; on error ignore command and data one cycle.
// - Command parity error raises exception, flag and uncorrectable pulse.
// - As master with valid asserted, drive the 8-bit bus ECC.
// - As slave, check bus ECC only with valid and command bit 0 high.
// - Correctable address or own-read data errors fixed in-line, pulse fires.
// - Uncorrectable address cycle: ignore one cycle, exception, flag, pulse.
// - Bad own-read data or quality bit 5 flags the incoming buffer entry.
// - Forwarding flagged block raises cache exception; word data raises bus error.
// - State bus is sent with odd parity on its own line.
module cbec_top
   import cbec_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [APB_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic l2_rd_valid,
   input wire logic [IDX_W-1:0] l2_rd_index,
   input wire logic [L2D_W-1:0] l2_rd_data,
   input wire logic [L2D_CHK_W-1:0] l2_data_check_bits,
   output logic l2_reread_req,
   output logic l2_out_valid,
   output logic [L2D_W-1:0] l2_out_data,
   input wire logic tag_rd_valid,
   input wire logic [IDX_W-1:0] tag_rd_index,
   input wire logic [TAG_W-1:0] tag_rd_data,
   input wire logic tag_wr_valid,
   input wire logic [TAG_W-1:0] tag_wr_data,
   input wire logic [TAG_CHK_W-1:0] l2_tag_check_bits_i,
   output logic [TAG_CHK_W-1:0] l2_tag_check_bits_o,
   output logic l2_tag_check_bits_oe_n,
   output logic [TAG_W-1:0] tag_wr_out,
   output logic tag_out_valid,
   output logic [TAG_W-1:0] tag_out,
   input wire logic bus_master,
   input wire logic mst_valid,
   input wire logic [CMD_W-1:0] mst_cmd,
   input wire logic [AD_W-1:0] mst_ad,
   input wire logic rd_pending,
   input wire cbec_sysbus_t bus_i,
   output cbec_sysbus_t bus_o,
   output logic bus_oe_n,
   output logic slv_valid,
   output logic [CMD_W-1:0] slv_cmd,
   output logic [AD_W-1:0] slv_ad,
   input wire logic fwd_valid,
   input wire logic fwd_block,
   input wire logic [IBUF_IDX_W-1:0] fwd_entry,
   input wire logic [IDX_W-1:0] fwd_index,
   input wire logic [STATE_W-1:0] state_in,
   output logic [STATE_W-1:0] state_bus,
   output logic state_parity,
   input wire logic response_valid,
   input wire logic [RESP_W-1:0] response_bus,
   input wire logic response_parity,
   output logic correctable_error_pulse_n,
   output logic uncorrectable_error_pulse_n,
   output logic cache_err_exc,
   output logic bus_err_exc
);
   // Register bus decode.
   wire apb_acc = psel & penable & ~pready;
   wire apb_done = psel & penable & pready;
   wire apb_wr = apb_done & pwrite;
   wire hit_ctrl = (paddr == REG_CTRL);
   wire hit_fault = (paddr == REG_FAULT);
   wire hit_perf = (paddr == REG_PERF0);
   wire hit_any = hit_ctrl | hit_fault | hit_perf;

   logic [31:0] ctrl_r;
   logic [FLT_FLAGS_W-1:0] flt_flags_r, flt_flags_nxt, flt_set, flt_clr;
   logic [IDX_W-1:0] flt_idx_r, flt_idx_nxt;
   logic [PERF_W-1:0] perf0_r, perf0_nxt;
   logic [31:0] prdata_r;
   logic pready_r, pslverr_r;
   wire corr_en = ctrl_r[CTRL_CORR_EN_BIT];

   // Data array path.
   cbec_dstate_t dstate_r, dstate_nxt;
   logic [L2D_W-1:0] d_fix;
   logic d_ce, d_ue;
   cbec_secded #(.K(L2D_W), .R(L2D_ECC_W)) u_data_ecc (
      .data(l2_rd_data),
      .chk(l2_data_check_bits[L2D_ECC_W-1:0]),
      .gen(),
      .fixed(d_fix),
      .ce(d_ce),
      .ue(d_ue)
   );
   wire use_ecc = corr_en | (dstate_r == DS_REREAD);
   wire d_par_err = ^{l2_rd_data, l2_data_check_bits[L2D_PAR_BIT]};
   wire d_par_fail = l2_rd_valid & ~use_ecc & d_par_err;
   wire d_raw_ok = l2_rd_valid & ~use_ecc & ~d_par_err;
   wire d_take = l2_rd_valid & use_ecc;
   wire data_ce = d_take & d_ce;
   wire data_ue = d_take & d_ue;

   always_comb begin
      dstate_nxt = dstate_r;
      unique case (dstate_r)
         DS_IDLE: begin
            if (d_par_fail) dstate_nxt = DS_REREAD;
         end
         DS_REREAD: begin
            if (l2_rd_valid) dstate_nxt = DS_IDLE;
         end
         default: dstate_nxt = DS_IDLE;
      endcase
   end

   // Tag path; a write takes the shared coder, and a read in the same cycle is dropped.
   logic [TAG_W-1:0] t_fix;
   logic [TAG_CHK_W-1:0] t_gen;
   logic t_ce, t_ue;
   wire [TAG_W-1:0] t_sel = tag_wr_valid ? tag_wr_data : tag_rd_data;
   cbec_secded #(.K(TAG_W), .R(TAG_CHK_W)) u_tag_ecc (
      .data(t_sel),
      .chk(l2_tag_check_bits_i),
      .gen(t_gen),
      .fixed(t_fix),
      .ce(t_ce),
      .ue(t_ue)
   );
   wire t_rd = tag_rd_valid & ~tag_wr_valid;
   wire tag_ce = t_rd & t_ce;
   wire tag_ue = t_rd & t_ue;

   // System bus path; the coder serves the master when it owns the bus.
   logic [AD_W-1:0] ad_fix;
   logic [AD_CHK_W-1:0] ad_gen;
   logic ad_ce, ad_ue;
   wire [AD_W-1:0] ad_sel = bus_master ? mst_ad : bus_i.ad;
   cbec_secded #(.K(AD_W), .R(AD_CHK_W)) u_ad_ecc (
      .data(ad_sel),
      .chk(bus_i.ad_chk),
      .gen(ad_gen),
      .fixed(ad_fix),
      .ce(ad_ce),
      .ue(ad_ue)
   );
   wire sv = ~bus_master & ~bus_i.valid_n;
   wire cpar_err = sv & ~(^{bus_i.cmd, bus_i.cmd_par});
   wire chk_en = sv & bus_i.cmd[CMD_CHK_EN_BIT] & ~cpar_err;
   wire addr_cyc = ~bus_i.cmd[CMD_DATA_BIT];
   wire data_cyc = bus_i.cmd[CMD_DATA_BIT] & rd_pending;
   wire ad_ce_ev = chk_en & ad_ce & (addr_cyc | data_cyc);
   wire ad_ue_addr = chk_en & ad_ue & addr_cyc;
   wire ignore = cpar_err | ad_ue_addr;
   wire ib_bad = (chk_en & ad_ue) | bus_i.cmd[CMD_QUAL_BIT];
   wire ib_set_ev = sv & ~cpar_err & data_cyc & ib_bad;
   wire [IBUF_IDX_W-1:0] ib_entry = bus_i.cmd[CMD_ENTRY_LSB +: IBUF_IDX_W];

   // Incoming buffer error flags; a new error wins over a forward clear.
   logic [IBUF_N-1:0] ibuf_r;
   for (genvar e = 0; e < IBUF_N; e++) begin : g_ibuf
      wire set_e = ib_set_ev & (ib_entry == IBUF_IDX_W'(e));
      wire clr_e = fwd_valid & (fwd_entry == IBUF_IDX_W'(e));
      always_ff @(posedge clk or negedge rstn) begin
         if (!rstn) ibuf_r[e] <= 1'b0;
         else ibuf_r[e] <= set_e | (ibuf_r[e] & ~clr_e);
      end
   end
   wire fwd_bad = fwd_valid & ibuf_r[fwd_entry];
   wire blk_err = fwd_bad & fwd_block;
   wire word_err = fwd_bad & ~fwd_block;

   wire resp_err = response_valid & ~(^{response_bus, response_parity});

   // Event summary.
   wire any_ce = data_ce | tag_ce | ad_ce_ev;
   wire any_ue = tag_ue | cpar_err | ad_ue_addr;
   wire any_exc = data_ue | tag_ue | cpar_err | ad_ue_addr | blk_err;

   // Fault register: hardware sets win over a software clear in the same cycle.
   always_comb begin
      flt_set = '0;
      flt_set[FLT_D_BIT] = data_ue | blk_err;
      flt_set[FLT_TA_BIT] = tag_ue;
      flt_set[FLT_SC_BIT] = cpar_err;
      flt_set[FLT_SA_BIT] = ad_ue_addr;
      flt_set[FLT_EE_BIT] = blk_err;
      flt_set[FLT_RP_BIT] = resp_err;
      flt_clr = (apb_wr & hit_fault) ? pwdata[FLT_FLAGS_W-1:0] : '0;
      flt_flags_nxt = (flt_flags_r & ~flt_clr) | flt_set;
      flt_idx_nxt = flt_idx_r;
      if (blk_err) flt_idx_nxt = fwd_index;
      if (tag_ue) flt_idx_nxt = tag_rd_index;
      if (data_ue) flt_idx_nxt = l2_rd_index;
      perf0_nxt = (apb_wr & hit_perf) ? pwdata : perf0_r;
      if (data_ce) perf0_nxt = perf0_nxt + 1'b1;
   end

   wire [31:0] rd_mux = hit_ctrl ? ctrl_r :
                        hit_fault ? {flt_idx_r, 10'h000, flt_flags_r} :
                        hit_perf ? perf0_r : 32'h0000_0000;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_r <= CTRL_RST;
         flt_flags_r <= FLT_FLAGS_RST;
         flt_idx_r <= FLT_IDX_RST;
         perf0_r <= PERF_RST;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
      end else begin
         if (apb_wr & hit_ctrl) ctrl_r <= pwdata;
         flt_flags_r <= flt_flags_nxt;
         flt_idx_r <= flt_idx_nxt;
         perf0_r <= perf0_nxt;
         pready_r <= apb_acc;
         pslverr_r <= apb_acc & ~hit_any;
         prdata_r <= apb_acc ? rd_mux : 32'h0000_0000;
      end
   end

   // Datapath and pin registers.
   logic reread_r, l2_ov_r, tag_ov_r, tag_oe_n_r, bus_oe_n_r, slv_valid_r;
   logic [L2D_W-1:0] l2_od_r;
   logic [TAG_W-1:0] tag_out_r, tag_wr_out_r;
   logic [TAG_CHK_W-1:0] tag_chk_o_r;
   cbec_sysbus_t bus_o_r;
   logic [CMD_W-1:0] slv_cmd_r;
   logic [AD_W-1:0] slv_ad_r;
   logic [STATE_W-1:0] state_r;
   logic state_par_r, corr_n_r, unc_n_r, cexc_r, bexc_r;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         dstate_r <= DS_IDLE;
         reread_r <= 1'b0;
         l2_ov_r <= 1'b0;
         l2_od_r <= '0;
         tag_ov_r <= 1'b0;
         tag_out_r <= '0;
         tag_wr_out_r <= '0;
         tag_chk_o_r <= '0;
         tag_oe_n_r <= 1'b1;
         bus_o_r <= '{valid_n: 1'b1, cmd_par: 1'b1, default: '0};
         bus_oe_n_r <= 1'b1;
         slv_valid_r <= 1'b0;
         slv_cmd_r <= '0;
         slv_ad_r <= '0;
         state_r <= '0;
         state_par_r <= 1'b1;
         corr_n_r <= 1'b1;
         unc_n_r <= 1'b1;
         cexc_r <= 1'b0;
         bexc_r <= 1'b0;
      end else begin
         dstate_r <= dstate_nxt;
         reread_r <= d_par_fail;
         l2_ov_r <= d_raw_ok | (d_take & ~d_ue);
         l2_od_r <= use_ecc ? d_fix : l2_rd_data;
         tag_ov_r <= t_rd & ~t_ue;
         tag_out_r <= t_fix;
         tag_wr_out_r <= tag_wr_data;
         tag_chk_o_r <= t_gen;
         tag_oe_n_r <= ~tag_wr_valid;
         bus_o_r.valid_n <= ~(bus_master & mst_valid);
         bus_o_r.cmd <= mst_cmd;
         bus_o_r.cmd_par <= ~(^mst_cmd);
         bus_o_r.ad <= mst_ad;
         bus_o_r.ad_chk <= ad_gen;
         bus_oe_n_r <= ~bus_master;
         slv_valid_r <= sv & ~ignore;
         slv_cmd_r <= bus_i.cmd;
         slv_ad_r <= chk_en ? ad_fix : bus_i.ad;
         state_r <= state_in;
         state_par_r <= ~(^state_in);
         corr_n_r <= ~any_ce;
         unc_n_r <= ~any_ue;
         cexc_r <= any_exc;
         bexc_r <= word_err;
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign l2_reread_req = reread_r;
   assign l2_out_valid = l2_ov_r;
   assign l2_out_data = l2_od_r;
   assign l2_tag_check_bits_o = tag_chk_o_r;
   assign l2_tag_check_bits_oe_n = tag_oe_n_r;
   assign tag_wr_out = tag_wr_out_r;
   assign tag_out_valid = tag_ov_r;
   assign tag_out = tag_out_r;
   assign bus_o = bus_o_r;
   assign bus_oe_n = bus_oe_n_r;
   assign slv_valid = slv_valid_r;
   assign slv_cmd = slv_cmd_r;
   assign slv_ad = slv_ad_r;
   assign state_bus = state_r;
   assign state_parity = state_par_r;
   assign correctable_error_pulse_n = corr_n_r;
   assign uncorrectable_error_pulse_n = unc_n_r;
   assign cache_err_exc = cexc_r;
   assign bus_err_exc = bexc_r;

   // Checks.
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   sequence s_par_fail;
      l2_rd_valid && !corr_en && dstate_r == DS_IDLE && d_par_err;
   endsequence
   sequence s_reread_done;
      l2_reread_req && dstate_r == DS_REREAD;
   endsequence
   sequence s_own_bad_data;
      sv && !cpar_err && data_cyc && bus_i.cmd[CMD_QUAL_BIT];
   endsequence

   reread_entry_a: assert property (s_par_fail |=> s_reread_done)
      else $error("parity failure did not start a re-read");
   reread_ecc_a: assert property ((dstate_r == DS_REREAD && data_ce) |=>
      !correctable_error_pulse_n && perf0_r == $past(perf0_r) + 1'b1)
      else $error("re-read correctable error not reported");
   data_corr_a: assert property (data_ce |=> !correctable_error_pulse_n)
      else $error("correctable data error without pulse");
   data_unc_a: assert property (data_ue |=> cache_err_exc && flt_flags_r[FLT_D_BIT]
      && flt_idx_r == $past(l2_rd_index))
      else $error("uncorrectable data error not logged");
   tag_unc_a: assert property (tag_ue |=> !uncorrectable_error_pulse_n
      && flt_flags_r[FLT_TA_BIT] && cache_err_exc)
      else $error("uncorrectable tag error not reported");
   tag_write_a: assert property (tag_wr_valid |=> !l2_tag_check_bits_oe_n
      && l2_tag_check_bits_o[TAG_CHK_W-1] == ^{$past(tag_wr_data), l2_tag_check_bits_o[5:0]})
      else $error("tag write check bits wrong");
   cmd_parity_a: assert property (!bus_o.valid_n |-> ^{bus_o.cmd, bus_o.cmd_par})
      else $error("master command parity not odd");
   cmd_ignore_a: assert property (cpar_err |=> !slv_valid && !uncorrectable_error_pulse_n
      && flt_flags_r[FLT_SC_BIT])
      else $error("command parity error not handled");
   addr_unc_a: assert property (ad_ue_addr |=> !slv_valid && cache_err_exc
      && flt_flags_r[FLT_SA_BIT])
      else $error("address cycle error not handled");
   ibuf_flag_a: assert property (s_own_bad_data |=> ibuf_r[$past(ib_entry)])
      else $error("incoming buffer flag not set");
   state_par_a: assert property (##1 ^{state_bus, state_parity})
      else $error("state parity not odd");
endmodule : cbec_top

/* File: sim/cbec_tb_pkg.sv */
// Purpose: Bench-side SECDED reference for the agent model and the testbench.
// Assumes: Hamming bits sit at power-of-two positions, overall parity on top.
// Notes: Written apart from the design, so that one slip cannot hide in both.
package cbec_tb_pkg;
   function automatic logic [15:0] cbec_tb_ecc(input logic [63:0] d, input int k,
      input int r);
      logic [15:0] c;
      int pos;
      c = 16'h0000;
      pos = 3;
      for (int j = 0; j < k; j++) begin
         while ((pos & (pos - 1)) == 0) begin
            pos++;
         end
         for (int i = 0; i < r - 1; i++) begin
            if (d[j] && pos[i]) c[i] = ~c[i];
         end
         pos++;
      end
      c[r - 1] = (^(d & ((64'h1 << k) - 64'h1))) ^ (^c);
      return c;
   endfunction : cbec_tb_ecc
endpackage : cbec_tb_pkg

/* File: sim/cbec_agent.sv */
// Purpose: Model of the external agent that masters the shared system bus.
// Assumes: A request starts right after a rising edge and lasts one cycle.
// Notes: Nothing holds the idle lines, so they show the inverse of the last value.
module cbec_agent
   import cbec_pkg::*;
   import cbec_tb_pkg::*;
(
   input wire logic clk,
   output cbec_sysbus_t bus
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      bus = '1;
   end
   // A set bad_par breaks parity and err_mask corrupts the wire on purpose.
   task automatic send(input logic [CMD_W-1:0] cmd, input logic [AD_W-1:0] ad,
      input logic bad_par, input logic [AD_W-1:0] err_mask);
      cbec_sysbus_t b;
      b.valid_n = 1'h0;
      b.cmd = cmd;
      b.cmd_par = ~(^cmd) ^ bad_par;
      b.ad = ad ^ err_mask;
      b.ad_chk = AD_CHK_W'(cbec_tb_ecc(ad, AD_W, AD_CHK_W));
      bus <= b;
      @(posedge clk);
      bus <= ~b;
   endtask : send
endmodule : cbec_agent

/* File: sim/test_cache_and_bus_error_check.sv */
// Purpose: Self-checking bench for the cache and bus error checker.
// Assumes: Results are registered one cycle after their cause.
// Notes: Response inputs follow the forward strobes; block forwards break parity.
module test_cache_and_bus_error_check
   import cbec_pkg::*;
   import cbec_tb_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rstn, psel, penable, pwrite, pready, pslverr, er;
   logic [APB_AW-1:0] paddr;
   logic [31:0] pwdata, prdata, rdv;
   logic l2_rd_valid, l2_reread_req, l2_out_valid, tag_rd_valid, tag_wr_valid;
   logic [IDX_W-1:0] l2_rd_index, tag_rd_index, fwd_index;
   logic [L2D_W-1:0] l2_rd_data, l2_out_data, d;
   logic [L2D_CHK_W-1:0] l2_data_check_bits;
   logic [TAG_W-1:0] tag_rd_data, tag_wr_data, tag_wr_out, tag_out;
   logic [TAG_CHK_W-1:0] l2_tag_check_bits_i, l2_tag_check_bits_o, tc;
   logic l2_tag_check_bits_oe_n, tag_out_valid, bus_master, mst_valid, rd_pending;
   logic [CMD_W-1:0] mst_cmd, slv_cmd;
   logic [AD_W-1:0] mst_ad, slv_ad;
   cbec_sysbus_t bus_i, bus_o;
   logic bus_oe_n, slv_valid, fwd_valid, fwd_block, state_parity;
   logic [IBUF_IDX_W-1:0] fwd_entry;
   logic [STATE_W-1:0] state_in, state_bus;
   logic correctable_error_pulse_n, uncorrectable_error_pulse_n, cache_err_exc, bus_err_exc;
   int bad_count, checks, cycles;
   cbec_top uut (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .l2_rd_valid, .l2_rd_index, .l2_rd_data, .l2_data_check_bits, .l2_reread_req,
      .l2_out_valid, .l2_out_data, .tag_rd_valid, .tag_rd_index, .tag_rd_data, .tag_wr_valid,
      .tag_wr_data, .l2_tag_check_bits_i, .l2_tag_check_bits_o, .l2_tag_check_bits_oe_n,
      .tag_wr_out, .tag_out_valid, .tag_out, .bus_master, .mst_valid, .mst_cmd, .mst_ad,
      .rd_pending, .bus_i, .bus_o, .bus_oe_n, .slv_valid, .slv_cmd, .slv_ad, .fwd_valid,
      .fwd_block, .fwd_entry, .fwd_index, .state_in, .state_bus, .state_parity,
      .response_valid(fwd_valid), .response_bus(5'h01), .response_parity(fwd_block),
      .correctable_error_pulse_n, .uncorrectable_error_pulse_n, .cache_err_exc, .bus_err_exc);
   cbec_agent uagent (.clk(clk), .bus(bus_i));
   initial begin
      clk = 1'h0;
      forever #20 clk = ~clk;
   end
   task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
      checks++;
      if (s !== e) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : end_sim
   always @(posedge clk) begin
      cycles++;
      if (cycles == 4000) begin
         bad_count++;
         end_sim();
      end
   end
   task automatic apb(input logic w, input logic [APB_AW-1:0] a, input logic [31:0] wd);
      @(posedge clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'h1;
      do @(posedge clk); while (pready !== 1'h1);
      rdv = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb
   // Flags are write-1-to-clear, so each check leaves the flag bits clean; the index field keeps its value.
   task automatic fault(input logic [31:0] m, input logic [31:0] e);
      apb(1'h0, REG_FAULT, 32'h0000_0000);
      chk("fault", 64'(rdv & m), 64'(e));
      apb(1'h1, REG_FAULT, 32'h0000_003F);
   endtask : fault
   task automatic pulses(input logic c, input logic u, input logic x);
      chk("cor_n", 64'(correctable_error_pulse_n), 64'(c));
      chk("unc_n", 64'(uncorrectable_error_pulse_n), 64'(u));
      chk("cache_exc", 64'(cache_err_exc), 64'(x));
   endtask : pulses
   task automatic l2(input logic [63:0] dd, input logic [9:0] c);
      @(posedge clk);
      l2_rd_valid <= 1'h1;
      l2_rd_data <= dd;
      l2_data_check_bits <= c;
      @(posedge clk);
      l2_rd_valid <= 1'h0;
      #1;
   endtask : l2
   task automatic t_data();
      logic [8:0] e;
      e = L2D_ECC_W'(cbec_tb_ecc(d, L2D_W, L2D_ECC_W));
      apb(1'h0, REG_PERF0, 32'h0000_0000);
      chk("perf_rst", 64'(rdv), 64'(PERF_RST));
      l2(d, {^d, 9'h000});
      chk("pass_valid", 64'(l2_out_valid), 64'h1);
      chk("pass_data", l2_out_data, d);
      l2(d, {~(^d), e});
      chk("reread", 64'({l2_reread_req, l2_out_valid}), 64'h2);
      l2(d ^ 64'h1_0000, {^d, e});
      chk("fix_data", l2_out_data, d);
      pulses(1'h0, 1'h1, 1'h0);
      apb(1'h0, REG_PERF0, 32'h0000_0000);
      chk("perf0", 64'(rdv), 64'h1);
      l2(d, {~(^d), e});
      l2(d ^ 64'h3, {^d, e});
      chk("no_out", 64'(l2_out_valid), 64'h0);
      chk("cache_exc", 64'(cache_err_exc), 64'h1);
      fault(32'hFFFF_003F, {l2_rd_index, 16'h0001});
      apb(1'h1, REG_CTRL, 32'h0000_0001);
      l2(d ^ 64'h1, {^d, e});
      chk("ecc_mode", l2_out_data, d);
      $display("t_data done");
   endtask : t_data
   task automatic tag(input logic w, input logic [TAG_W-1:0] t, input logic [6:0] c);
      @(posedge clk);
      tag_wr_valid <= w;
      tag_rd_valid <= ~w;
      tag_wr_data <= t;
      tag_rd_data <= t;
      l2_tag_check_bits_i <= c;
      @(posedge clk);
      tag_wr_valid <= 1'h0;
      tag_rd_valid <= 1'h0;
      #1;
   endtask : tag
   task automatic t_tag();
      logic [TAG_W-1:0] t;
      t = 26'h2A5_C3F1;
      tc = TAG_CHK_W'(cbec_tb_ecc(64'(t), TAG_W, TAG_CHK_W));
      tag(1'h1, t, 7'h00);
      chk("tag_oe_n", 64'(l2_tag_check_bits_oe_n), 64'h0);
      chk("tag_chk", 64'(l2_tag_check_bits_o), 64'(tc));
      chk("tag_wr", 64'(tag_wr_out), 64'(t));
      tag(1'h0, t ^ 26'h400, tc);
      chk("tag_fix", 64'({tag_out_valid, tag_out}), 64'({1'h1, t}));
      pulses(1'h0, 1'h1, 1'h0);
      tag(1'h0, t ^ 26'h3, tc);
      pulses(1'h1, 1'h0, 1'h1);
      fault(32'hFFFF_003F, {tag_rd_index, 16'h0002});
      $display("t_tag done");
   endtask : t_tag
   task automatic t_master();
      for (int s = 0; s < 8; s++) begin
         @(posedge clk);
         bus_master <= 1'h1;
         mst_valid <= 1'h1;
         mst_cmd <= 12'hA5C ^ CMD_W'(s);
         mst_ad <= d ^ 64'(s);
         state_in <= STATE_W'(s);
         @(posedge clk);
         #1;
         chk("m_valid_n", 64'({bus_oe_n, bus_o.valid_n}), 64'h0);
         chk("m_cmdpar", 64'(^{bus_o.cmd, bus_o.cmd_par}), 64'h1);
         chk("m_adchk", 64'(bus_o.ad_chk), 64'(cbec_tb_ecc(d ^ 64'(s), 64, 8)));
         chk("st_par", 64'({state_bus, ^{state_bus, state_parity}}), 64'({s[2:0], 1'h1}));
      end
      mst_valid <= 1'h0;
      bus_master <= 1'h0;
      $display("t_master done");
   endtask : t_master
   task automatic slave(input logic [11:0] c, input logic bp, input logic [63:0] m);
      @(posedge clk);
      uagent.send(c, d, bp, m);
      #1;
   endtask : slave
   task automatic t_slave();
      slave(12'h001, 1'h0, 64'h8);
      chk("s_fix", 64'(slv_ad), d);
      pulses(1'h0, 1'h1, 1'h0);
      slave(12'h000, 1'h0, 64'h8);
      chk("s_nochk", 64'(slv_ad), d ^ 64'h8);
      chk("s_nochk_cor", 64'({slv_cmd, correctable_error_pulse_n}), 64'h1);
      slave(12'h001, 1'h1, 64'h0);
      chk("s_ign_par", 64'(slv_valid), 64'h0);
      pulses(1'h1, 1'h0, 1'h1);
      fault(32'h0000_003F, 32'h0000_0004);
      slave(12'h001, 1'h0, 64'h6);
      chk("s_ign_ue", 64'(slv_valid), 64'h0);
      pulses(1'h1, 1'h0, 1'h1);
      fault(32'h0000_003F, 32'h0000_0008);
      $display("t_slave done");
   endtask : t_slave
   task automatic fwd(input logic b, input logic [1:0] e, input logic [1:0] exp);
      @(posedge clk);
      fwd_valid <= 1'h1;
      fwd_block <= b;
      fwd_entry <= e;
      @(posedge clk);
      fwd_valid <= 1'h0;
      #1;
      chk("fwd_exc", 64'({cache_err_exc, bus_err_exc}), 64'(exp));
   endtask : fwd
   task automatic t_fwd();
      rd_pending <= 1'h1;
      slave(12'h822, 1'h0, 64'h0);
      slave(12'h805, 1'h0, 64'h300);
      rd_pending <= 1'h0;
      fwd(1'h1, 2'h3, 2'h0);
      fwd(1'h1, 2'h1, 2'h2);
      fault(32'hFFFF_0031, {fwd_index, 16'h0031});
      fwd(1'h0, 2'h2, 2'h1);
      fwd(1'h1, 2'h1, 2'h0);
      $display("t_fwd done");
   endtask : t_fwd
   initial begin
      {rstn, psel, penable, pwrite, paddr, pwdata, l2_rd_valid, l2_rd_data} = '0;
      {l2_data_check_bits, tag_rd_valid, tag_rd_data, tag_wr_valid, tag_wr_data} = '0;
      {l2_tag_check_bits_i, bus_master, mst_valid, mst_cmd, mst_ad, rd_pending} = '0;
      {fwd_valid, fwd_block, fwd_entry, state_in} = '0;
      l2_rd_index = 16'h1234;
      tag_rd_index = 16'h0567;
      fwd_index = 16'h0ABC;
      d = 64'h0123_4567_89AB_CDEF;
      bad_count = 0;
      checks = 0;
      cycles = 0;
      repeat (2) @(posedge clk);
      rstn <= 1'h1;
      #1;
      pulses(1'h1, 1'h1, 1'h0);
      apb(1'h0, REG_CTRL, 32'h0000_0000);
      chk("ctrl_rst", 64'(rdv), 64'(CTRL_RST));
      fault(32'hFFFF_FFFF, 32'h0000_0000);
      apb(1'h1, 12'h0FC, 32'hFFFF_FFFF);
      apb(1'h0, 12'h0FC, 32'h0000_0000);
      chk("unmapped", 64'({er, rdv}), 64'h1_0000_0000);
      t_data();
      t_tag();
      t_master();
      t_slave();
      t_fwd();
      end_sim();
   end
endmodule : test_cache_and_bus_error_check
